// File: rtl/dac_link_defines.svh
// Constants shared by both ends of the dual converter serial link
`ifndef DAC_LINK_DEFINES_SVH
`define DAC_LINK_DEFINES_SVH

// Word layout on the link
`define WORD_BITS 5'h10
`define BYTE_BITS 5'h08
`define LATCH_A_ROUTE_POS 15
`define SPEED_SELECT_POS 14
`define POWER_DOWN_POS 13
`define BUFFER_ONLY_POS 12
`define CODE_MSB_POS 11

// Reset values
`define CODE_RST 12'h000
`define WORD_RST 16'h0000

// Controller register byte offsets on the Avalon slave
`define WORD_OFS 4'h0
`define CTRL_OFS 4'h4
`define STAT_OFS 4'h8

// Controller register field positions
`define CTRL_GO_POS 0
`define CTRL_BYTE_POS 1
`define STAT_BUSY_POS 0
`define STAT_SPEED_CHG_POS 1

// Timing: system clock rate and the pause between two bytes
`define CLK_MHZ 20
`define BYTE_PAUSE_NS 100
`define BYTE_PAUSE_CYC (((`BYTE_PAUSE_NS * `CLK_MHZ) + 999) / 1000)

`endif

// File: rtl/dac_link_device.sv
// Converter end: serial holding register and latch routing
//
// Summary of operation
// - Select low: shift sixteen bits, MSB first
// - Sample data on serial clock falling edge
// - Select rising moves word into latches
// - Select high: clock edges ignored
// - Bit 15 set: A loads, B from buffer
// - Bits 15,12 clear: B and buffer load
// - Bit 15 clear, 12 set: buffer only
// - Bit 14 picks slow or fast settling
// - Bit 13 set enters power down
// - Transfers at select rise, or at the sixteenth clock when self-counting
// - Bits 11 to 0 form the code
// - Self-count: lock after sixteen clocks
// - End of count ORed with select
// - Host serial clock at most 20 MHz
// - Frame is sixteen clocks plus setup
// - Byte hosts send two bytes, select low
// - Host keeps speed bit unchanged; controller passes changes on and sets a sticky flag
// - Power-up clears all latch contents
`timescale 1ns/1ps
`include "dac_link_defines.svh"
module dac_link_device #(
  parameter bit SELF_COUNT = 1'b1
) (
  // Power-on clear
  input wire logic reset,
  // Serial link, clocked by the link's own clock
  dac_link_if.device link,
  // Converter latch contents
  output dac_link_pkg::code_t latch_a_code,
  output dac_link_pkg::code_t latch_b_code,
  output dac_link_pkg::code_t dbuf_code,
  // Output mode
  output logic fast_mode,
  output logic power_down,
  // Frame observation
  output dac_link_pkg::route_e last_route,
  output logic [4:0] frame_bits,
  output logic frame_overrun,
  output logic [7:0] update_count
);
  import dac_link_pkg::*;

  // Link side state
  word_t serial_holding_reg_ff;
  logic [4:0] bit_cnt_ff;
  logic extra_clk_ff;

  // Latch side state
  code_t latch_a_ff;
  code_t latch_b_ff;
  code_t dbuf_ff;
  logic fast_ff;
  logic pd_ff;
  route_e route_ff;
  logic [4:0] frame_bits_ff;
  logic overrun_ff;
  logic [7:0] update_count_ff;

  // Decoded frame controls
  wire cnt_done;
  wire locked;
  wire frame_clr;
  wire shift_en;
  wire update_clk;

  // Decoded word fields
  wire latch_a_route_bit;
  wire speed_select_bit;
  wire power_down_bit;
  wire buffer_only_bit;
  code_t word_code;

  // Next latch and bit counter values
  code_t nxt_latch_a;
  code_t nxt_latch_b;
  code_t nxt_dbuf;
  route_e nxt_route;
  logic [4:0] nxt_bit_cnt;
  logic [7:0] nxt_update_count;

  // Frame count state
  assign cnt_done = (bit_cnt_ff == `WORD_BITS);
  assign locked = SELF_COUNT && cnt_done;
  assign frame_clr = reset | link.cs_n;
  assign shift_en = !link.cs_n && !locked;
  assign update_clk = link.cs_n | locked;

  // Field decode of the held word
  assign latch_a_route_bit = serial_holding_reg_ff[`LATCH_A_ROUTE_POS];
  assign speed_select_bit = serial_holding_reg_ff[`SPEED_SELECT_POS];
  assign power_down_bit = serial_holding_reg_ff[`POWER_DOWN_POS];
  assign buffer_only_bit = serial_holding_reg_ff[`BUFFER_ONLY_POS];
  assign word_code = serial_holding_reg_ff[`CODE_MSB_POS:0];

  assign nxt_latch_a = latch_a_route_bit ? word_code : latch_a_ff;
  assign nxt_latch_b = latch_a_route_bit ? dbuf_ff :
                       (buffer_only_bit ? latch_b_ff : word_code);
  assign nxt_dbuf = latch_a_route_bit ? dbuf_ff : word_code;

  // Routing taken by this transfer
  assign nxt_route = latch_a_route_bit ? ROUTE_A :
                     (buffer_only_bit ? ROUTE_BUF : ROUTE_B_BUF);

  // Frame bit counter saturates at one word
  assign nxt_bit_cnt = cnt_done ? bit_cnt_ff : bit_cnt_ff + 5'h01;
  assign nxt_update_count = update_count_ff + 8'h01;

  always_ff @(negedge link.sclk or posedge reset)
  begin
    if (reset)
      serial_holding_reg_ff <= `WORD_RST;
    else if (shift_en)
      serial_holding_reg_ff <= {serial_holding_reg_ff[14:0], link.din};
  end

  always_ff @(negedge link.sclk or posedge frame_clr)
  begin
    if (frame_clr)
      bit_cnt_ff <= 5'h00;
    else
      bit_cnt_ff <= nxt_bit_cnt;
  end

  // Clock beyond a full word in a frame
  always_ff @(negedge link.sclk or posedge frame_clr)
  begin
    if (frame_clr)
      extra_clk_ff <= 1'b0;
    else if (cnt_done)
      extra_clk_ff <= 1'b1;
  end

  always_ff @(posedge update_clk or posedge reset)
  begin
    if (reset)
    begin
      latch_a_ff <= `CODE_RST;
      latch_b_ff <= `CODE_RST;
      dbuf_ff <= `CODE_RST;
    end
    else
    begin
      latch_a_ff <= nxt_latch_a;
      latch_b_ff <= nxt_latch_b;
      dbuf_ff <= nxt_dbuf;
    end
  end

  always_ff @(posedge update_clk or posedge reset)
  begin
    if (reset)
    begin
      fast_ff <= 1'b0;
      pd_ff <= 1'b0;
    end
    else
    begin
      fast_ff <= speed_select_bit;
      pd_ff <= power_down_bit;
    end
  end

  // Record of the last frame, seen before the counter clears
  always_ff @(posedge update_clk or posedge reset)
  begin
    if (reset)
    begin
      route_ff <= ROUTE_NONE;
      frame_bits_ff <= 5'h00;
      overrun_ff <= 1'b0;
      update_count_ff <= 8'h00;
    end
    else
    begin
      route_ff <= nxt_route;
      frame_bits_ff <= bit_cnt_ff;
      overrun_ff <= extra_clk_ff;
      update_count_ff <= nxt_update_count;
    end
  end

  // Outputs straight from the latch flops
  assign latch_a_code = latch_a_ff;
  assign latch_b_code = latch_b_ff;
  assign dbuf_code = dbuf_ff;
  assign fast_mode = fast_ff;
  assign power_down = pd_ff;
  assign last_route = route_ff;
  assign frame_bits = frame_bits_ff;
  assign frame_overrun = overrun_ff;
  assign update_count = update_count_ff;

endmodule : dac_link_device

// File: rtl/dac_link_host.sv
// Controller end: Avalon slave registers and link sequencer
`timescale 1ns/1ps
`include "dac_link_defines.svh"
module dac_link_host (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Serial link
  dac_link_if.host link
);
  import dac_link_pkg::*;

  host_state_e state_ff;
  host_state_e nxt_state;
  dac_link_pkg::word_t word_ff;
  dac_link_pkg::word_t shift_ff;
  logic byte_mode_ff;
  logic speed_chg_ff;
  logic last_speed_ff;
  logic ack_ff;
  logic [31:0] readdata_ff;
  logic cs_n_ff;
  logic sclk_ff;
  logic din_ff;
  logic [4:0] bits_left;
  logic bits_zero;
  logic [2:0] pause_left;
  logic pause_zero;

  // Register decode
  wire sel_word = (address == `WORD_OFS);
  wire sel_ctrl = (address == `CTRL_OFS);
  wire sel_stat = (address == `STAT_OFS);
  wire busy = (state_ff != ST_IDLE);
  wire stall = write && busy && (sel_word || sel_ctrl);
  wire wr_fire = write && ack_ff;
  wire go = wr_fire && sel_ctrl && writedata[`CTRL_GO_POS];
  wire spd_clr = wr_fire && sel_stat && writedata[`STAT_SPEED_CHG_POS];
  wire spd_diff = word_ff[`SPEED_SELECT_POS] != last_speed_ff;
  wire st_low = (state_ff == ST_LOW);
  wire st_pause = (state_ff == ST_PAUSE);
  wire last_bit = (bits_left == 5'h01);
  wire byte_gap = byte_mode_ff && (bits_left == (`BYTE_BITS + 5'h01));
  wire [31:0] rd_mux = sel_word ? {16'h0000, word_ff} :
                       sel_ctrl ? {30'h0, byte_mode_ff, 1'b0} :
                       sel_stat ? {30'h0, speed_chg_ff, busy} : 32'h0;

  assign waitrequest = !ack_ff;
  assign readdata = readdata_ff;
  assign link.cs_n = cs_n_ff;
  assign link.sclk = sclk_ff;
  assign link.din = din_ff;

  // Bit and pause counters
  tick_counter #(.W(5)) u_bits (
    .clk(clk),
    .reset(reset),
    .load(go),
    .load_val(`WORD_BITS),
    .dec(st_low),
    .count(bits_left),
    .zero(bits_zero)
  );

  tick_counter #(.W(3)) u_pause (
    .clk(clk),
    .reset(reset),
    .load(st_low && byte_gap),
    .load_val(3'(`BYTE_PAUSE_CYC)),
    .dec(st_pause),
    .count(pause_left),
    .zero(pause_zero)
  );

  // Sequencer next state; one clk per sclk phase gives 10 MHz
  // Clock below limit
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (go) nxt_state = ST_HIGH;
      ST_HIGH: nxt_state = ST_LOW;
      ST_LOW:
        if (last_bit)
          nxt_state = ST_END;
        else if (byte_gap)
          nxt_state = ST_PAUSE;
        else
          nxt_state = ST_HIGH;
      ST_PAUSE: if (pause_zero) nxt_state = ST_HIGH;
      ST_END: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Bus handshake: answer one cycle after the request; word and control writes held off while busy
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ack_ff <= 1'b0;
      readdata_ff <= 32'h0;
    end
    else
    begin
      ack_ff <= (read || write) && !ack_ff && !stall;
      readdata_ff <= rd_mux;
    end
  end

  // Software registers, sticky flag set wins over clear
  // Flag speed change
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      word_ff <= `WORD_RST;
      byte_mode_ff <= 1'b0;
      speed_chg_ff <= 1'b0;
      last_speed_ff <= 1'b0;
    end
    else
    begin
      if (wr_fire && sel_word)
        word_ff <= writedata[15:0];
      if (wr_fire && sel_ctrl)
        byte_mode_ff <= writedata[`CTRL_BYTE_POS];
      if (go)
        last_speed_ff <= word_ff[`SPEED_SELECT_POS];
      if (go && spd_diff)
        speed_chg_ff <= 1'b1;
      else if (spd_clr)
        speed_chg_ff <= 1'b0;
    end
  end

  // Link pins, MSB first, data set while sclk high
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= ST_IDLE;
      shift_ff <= `WORD_RST;
      cs_n_ff <= 1'b1;
      sclk_ff <= 1'b1;
      din_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      sclk_ff <= (nxt_state != ST_LOW);
      cs_n_ff <= (nxt_state == ST_IDLE);
      if (go)
      begin
        shift_ff <= {word_ff[14:0], 1'b0};
        din_ff <= word_ff[15];
      end
      else if (st_low && !last_bit)
      begin
        shift_ff <= {shift_ff[14:0], 1'b0};
        din_ff <= shift_ff[15];
      end
    end
  end

endmodule : dac_link_host

// File: rtl/dac_link_if.sv
// Three-wire link between the controller and the converter
`timescale 1ns/1ps
interface dac_link_if;
  logic cs_n;
  logic sclk;
  logic din;

  // Controller drives every wire
  modport host (
    output cs_n,
    output sclk,
    output din
  );

  // Converter only listens
  modport device (
    input cs_n,
    input sclk,
    input din
  );
endinterface : dac_link_if

// File: rtl/dac_link_pkg.sv
// Types shared by both ends of the dual converter serial link
package dac_link_pkg;

  typedef logic [11:0] code_t;
  typedef logic [15:0] word_t;

  // Controller sequencer, Gray coded along idle-high-low-end
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_HIGH  = 3'h1,
    ST_LOW   = 3'h3,
    ST_END   = 3'h2,
    ST_PAUSE = 3'h6
  } host_state_e;

  // Latch routing of the last transfer
  typedef enum logic [1:0] {
    ROUTE_NONE  = 2'h0,
    ROUTE_A     = 2'h1,
    ROUTE_B_BUF = 2'h3,
    ROUTE_BUF   = 2'h2
  } route_e;

endpackage : dac_link_pkg

// File: rtl/tick_counter.sv
// Loadable down counter with a zero flag
`timescale 1ns/1ps
module tick_counter #(
  parameter int W = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic dec,
  // Status
  output logic [W-1:0] count,
  output logic zero
);

  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;

  // Load wins over decrement, stop at zero
  assign nxt_count = load ? load_val :
                     (dec && count_ff != '0) ? count_ff - 1'b1 : count_ff;
  assign count = count_ff;
  assign zero = (count_ff == '0);

  // Count register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      count_ff <= '0;
    else
      count_ff <= nxt_count;
  end

endmodule : tick_counter

// File: verif/dac_link_sva.sv
// Concurrent checks on the three-wire link and the latch outputs
`timescale 1ns/1ps
module dac_link_sva
  import dac_link_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  // Converter state
  input wire dac_link_pkg::code_t latch_a_code,
  input wire dac_link_pkg::code_t latch_b_code,
  input wire dac_link_pkg::code_t dbuf_code,
  input wire logic fast_mode,
  input wire logic power_down,
  input wire dac_link_pkg::route_e last_route,
  input wire logic [4:0] frame_bits,
  input wire logic frame_overrun,
  input wire logic [7:0] update_count
);
  import dac_link_pkg::*;
  logic [15:0] sh_ff;
  logic [4:0] nf_ff;
  logic [7:0] uc_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Shadow of the word and fall count seen on the wire
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      sh_ff <= 16'h0000;
      nf_ff <= 5'h00;
      uc_ff <= 8'h00;
    end
    else
    begin
      if ($fell(sclk) && !cs_n)
        sh_ff <= {sh_ff[14:0], din};
      if (cs_n)
        nf_ff <= 5'h00;
      else if ($fell(sclk))
        nf_ff <= nf_ff + 5'h01;
      if ($fell(cs_n))
        uc_ff <= update_count;
    end

  // Frame steps
  sequence s_start;
    $fell(cs_n) ##1 !cs_n[*7];
  endsequence
  sequence s_end;
    $rose(cs_n);
  endsequence

  a_latch_quiet: assert property (!$fell(sclk) && !$rose(cs_n) |->
    $stable({latch_a_code, latch_b_code, dbuf_code}))
    else $error("latch changed without link edge");
  a_idle_high: assert property (cs_n |-> sclk)
    else $error("serial clock low while deselected");
  a_frame_span: assert property (s_start |-> ##[20:30] cs_n)
    else $error("frame length out of range");
  a_end_setup: assert property (s_end |-> sclk && $past(sclk))
    else $error("select rose without clock high");
  a_route_a: assert property (s_end and sh_ff[15] |->
    latch_a_code == sh_ff[11:0] && latch_b_code == dbuf_code)
    else $error("latch A route wrong");
  a_route_b: assert property (s_end and sh_ff[15:12] ==? 4'b0??0 |->
    latch_b_code == sh_ff[11:0] && dbuf_code == sh_ff[11:0])
    else $error("latch B route wrong");
  a_route_buf: assert property (s_end and sh_ff[15:12] ==? 4'b0??1 |->
    dbuf_code == sh_ff[11:0] && last_route == ROUTE_BUF)
    else $error("buffer route wrong");
  a_mode_bits: assert property (s_end |->
    fast_mode == sh_ff[14] && power_down == sh_ff[13])
    else $error("mode bits wrong");
  a_frame_count: assert property (s_end |-> nf_ff == 5'h10 &&
    frame_bits == 5'h10 && !frame_overrun)
    else $error("frame bit count wrong");
  a_count_step: assert property (s_end |-> update_count == uc_ff + 8'h01)
    else $error("update count wrong");
endmodule : dac_link_sva

// File: verif/tb_top.sv
// Self-checking bench for the controller and converter pair
`timescale 1ns/1ps
`include "dac_link_defines.svh"
module tb_top;
  import dac_link_pkg::*;
  typedef struct packed {
    logic [15:0] w;
    logic bm;
    code_t a;
    code_t b;
    code_t d;
    route_e rt;
    logic fm;
    logic pd;
  } row_s;
  localparam row_s ROWS [6] = '{
    '{16'h8ABC, 1'b0, 12'hABC, 12'h000, 12'h000, ROUTE_A, 1'b0, 1'b0},
    '{16'h1123, 1'b0, 12'hABC, 12'h000, 12'h123, ROUTE_BUF, 1'b0, 1'b0},
    '{16'hC456, 1'b0, 12'h456, 12'h123, 12'h123, ROUTE_A, 1'b1, 1'b0},
    '{16'h6789, 1'b0, 12'h456, 12'h789, 12'h789, ROUTE_B_BUF, 1'b1, 1'b1},
    '{16'h5FFF, 1'b1, 12'h456, 12'h789, 12'hFFF, ROUTE_BUF, 1'b1, 1'b0},
    '{16'h8000, 1'b1, 12'h000, 12'hFFF, 12'hFFF, ROUTE_A, 1'b0, 1'b0}};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic [31:0] rd;
  logic waitrequest;
  code_t a_c, b_c, d_c, a2, b2, d2;
  logic fm, pd, ovr, fm2, pd2, ovr2;
  route_e rte, rte2;
  logic [4:0] fb, fb2;
  logic [7:0] uc, uc2;
  code_t a3, b3, d3;
  logic pd3, ovr3;
  logic [4:0] fb3;
  logic [7:0] uc3;
  int mismatches = 0;
  int n_tests = 0;
  dac_link_if lk ();
  dac_link_if lk2 ();

  // Pair under test and a converter driven by the bench
  dac_link_host i_dac_link_host (.clk(clk), .reset(reset),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .link(lk.host));
  dac_link_device i_dac_link_device (.reset(reset), .link(lk.device),
    .latch_a_code(a_c), .latch_b_code(b_c), .dbuf_code(d_c),
    .fast_mode(fm), .power_down(pd), .last_route(rte), .frame_bits(fb),
    .frame_overrun(ovr), .update_count(uc));
  dac_link_device i_dac_link_device2 (.reset(reset), .link(lk2.device),
    .latch_a_code(a2), .latch_b_code(b2), .dbuf_code(d2),
    .fast_mode(fm2), .power_down(pd2), .last_route(rte2), .frame_bits(fb2),
    .frame_overrun(ovr2), .update_count(uc2));
  // Externally timed variant on the same bench-driven link
  dac_link_device #(.SELF_COUNT(1'b0)) i_dac_link_device3 (.reset(reset),
    .link(lk2.device), .latch_a_code(a3), .latch_b_code(b3),
    .dbuf_code(d3), .fast_mode(), .power_down(pd3), .last_route(),
    .frame_bits(fb3), .frame_overrun(ovr3), .update_count(uc3));
  dac_link_sva i_dac_link_sva (.clk(clk), .reset(reset), .cs_n(lk.cs_n),
    .sclk(lk.sclk), .din(lk.din), .latch_a_code(a_c), .latch_b_code(b_c),
    .dbuf_code(d_c), .fast_mode(fm), .power_down(pd), .last_route(rte),
    .frame_bits(fb), .frame_overrun(ovr), .update_count(uc));

  // Clock
  always #25 clk = ~clk;

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One Avalon cycle; answer and read data taken at a rising edge
  task automatic bus(input logic wr, input logic [3:0] ad,
                     input logic [31:0] wd);
    int i;
    address <= ad;
    write <= wr;
    read <= !wr;
    writedata <= wd;
    for (i = 0; i < 200; i++)
    begin
      @(posedge clk);
      if (waitrequest === 1'b0)
        break;
    end
    if (i == 200)
    begin
      mismatches++;
      results();
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic send(input logic [15:0] w, input logic bm);
    int k;
    bus(1'b1, `WORD_OFS, {16'h0000, w});
    bus(1'b1, `CTRL_OFS, {30'h0, bm, 1'b1});
    // Write answer carries no status, so always poll at least once
    rd = 32'h1;
    for (k = 0; k < 60 && rd[0] !== 1'b0; k++)
      bus(1'b0, `STAT_OFS, 32'h0);
    if (k == 60)
    begin
      mismatches++;
      results();
    end
  endtask : send

  // Bench-driven frame of n bits, MSB first
  task automatic drv(input logic [19:0] w, input int n);
    lk2.cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge clk);
      lk2.din <= w[i];
      @(posedge clk);
      lk2.sclk <= 1'b0;
      @(posedge clk);
      lk2.sclk <= 1'b1;
    end
    lk2.din <= !w[0];
    @(posedge clk);
    lk2.cs_n <= 1'b1;
    @(posedge clk);
  endtask : drv

  initial
  begin
    lk2.cs_n = 1'b1;
    lk2.sclk = 1'b1;
    lk2.din = 1'b0;
    rd = 32'h1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({a_c, b_c, d_c, uc}, 64'h0);
    for (int r = 0; r < 6; r++)
    begin
      rd = 32'h1;
      send(ROWS[r].w, ROWS[r].bm);
      chk({a_c, b_c, d_c}, {ROWS[r].a, ROWS[r].b, ROWS[r].d});
      chk({rte, fm, pd, uc}, {ROWS[r].rt, ROWS[r].fm, ROWS[r].pd, 8'(r + 1)});
      chk({fb, ovr}, {5'h10, 1'b0});
      $display("row %0d done", r);
    end
    bus(1'b0, `STAT_OFS, 32'h0);
    chk(rd, 32'h2);
    bus(1'b1, `STAT_OFS, 32'h2);
    bus(1'b0, `STAT_OFS, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `WORD_OFS, 32'hFFFF1234);
    bus(1'b0, `WORD_OFS, 32'h0);
    chk(rd, 32'h1234);
    bus(1'b0, 4'hC, 32'h0);
    chk(rd, 32'h0);
    // Word write during a frame must wait until the frame ends
    bus(1'b1, `CTRL_OFS, 32'h1);
    bus(1'b1, `WORD_OFS, 32'h0ABC);
    bus(1'b0, `STAT_OFS, 32'h0);
    chk({rd, d_c}, {32'h0, 12'h234});
    $display("register test done");
    drv({16'h8321, 4'hF}, 20);
    chk({a2, uc2, fb2}, {12'h321, 8'h01, 5'h10});
    chk({a3, b3, d3, pd3, fb3, ovr3, uc3}, {24'h0, 12'h21F, 1'b1, 5'h10, 1'b1, 8'h01});
    repeat (4)
    begin
      @(posedge clk);
      lk2.sclk <= 1'b0;
      lk2.din <= 1'b1;
      @(posedge clk);
      lk2.sclk <= 1'b1;
    end
    chk({a2, uc2}, {12'h321, 8'h01});
    drv({12'h000, 8'hA5}, 8);
    chk({b2, d2, pd2, uc2, fb2}, {12'h1A5, 12'h1A5, 1'b1, 8'h02, 5'h08});
    chk({d3, pd3, fb3, ovr3, uc3}, {12'hFA5, 1'b0, 5'h08, 1'b0, 8'h02});
    $display("bench-driven link test done");
    // Reset in mid-run clears the host-driven converter's three latches and latch A of the bench-driven one again
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({a_c, b_c, d_c, uc, a2, uc2}, 64'h0);
    $display("reset test done");
    results();
  end
endmodule : tb_top
